// ### rtl/rsw_slave.sv
// two-wire slave of the rtc with override entry and interface watchdog
// Notes on behaviour
// - override entry ends internal reset at once; bus accesses then work.
// - permit bit at zero clears override mode.
// - override cannot be re-entered until the permit bit is one again.
// - permit bit zero otherwise only blocks override entry.
// - sda change while scl high is a control condition, not data.
// - idle bus is high; sda falling with scl high is start.
// - sda rising with scl high is stop and ends the transfer.
// - bytes are eight bits, each followed by an acknowledge clock.
// - addressed receiving slave acknowledges every byte, except a data byte while the write fifo is full.
// - acknowledger holds sda low through the ack clock high time.
// - after master no-ack the slave releases sda for the stop.
// - slave only: scl is input, sda is two-way.
// - answer read address a3 and write address a2.
// - register byte gives a 4-bit index; upper bits ignored.
// - time counters frozen while an access is in progress.
// - stalled access is cleared and counters resume.
// - watchdog fires between 1 s and 2 s after valid address.
// - each watchdog expiry loses exactly one counted second.
// - internal reset ignores all bus traffic.
// - internal reset clears interface logic and register pointer.
`timescale 1ns/1ns
module rsw_slave
    import rsw_pkg::*;
#(
    parameter int unsigned WDOG_CYCLES = RSW_WDOG_CYC,
    parameter int unsigned OVR_HOLD    = RSW_OVR_HOLD_CYC
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire logic         scl_i,
    input  wire logic         sda_i,
    output logic              sda_o,
    output logic              sda_oe,
    input  wire logic         osc_stopped,
    input  wire logic         override_permit_bit,
    output logic              override_active,
    output logic              time_freeze,
    output logic              sec_lost,
    output logic [3:0]        rd_addr,
    input  wire logic [7:0]   rd_data,
    output logic              wr_valid,
    input  wire logic         wr_ready,
    output rsw_wr_s           wr_word
);
    logic [1:0] rst_sync_ff;
    logic       rst_i_n;
    logic [2:0] pin_raw;
    logic [2:0] s1_ff;
    logic [2:0] s2_ff;
    logic [2:0] s3_ff;
    logic [2:0] filt_ff;
    logic [2:0] prev_ff;
    logic       scl_f;
    logic       sda_f;
    logic       osc_f;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       ireset;
    rsw_state_e st_ff;
    rsw_state_e after_ff;
    logic [3:0] bit_ff;
    logic [7:0] shr_ff;
    logic [3:0] ptr_ff;
    logic       oe_ff;
    logic       active_ff;
    logic [31:0] wdog_ff;
    logic       wdog_fire;
    logic       lost_ff;
    logic       ovr_ff;
    logic [1:0] step_ff;
    logic [31:0] hold_ff;
    logic [1:0] pat_now;
    logic [1:0] pat_next;
    logic       byte_in;
    logic       push;
    rsw_wr_s    fifo_in;
    logic       wr_ready_i;

    // reset release through two flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_ff <= 2'h0;
        end else if (clk_en) begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_i_n = rst_sync_ff[1];

    // three-flop sampling; a change counts once flops two and three agree
    assign pin_raw = {osc_stopped, sda_i, scl_i};
    for (genvar g = 0; g < 3; g++) begin : g_sync
        always_ff @(posedge core_clk or negedge rst_i_n) begin
            if (!rst_i_n) begin
                s1_ff[g]   <= 1'b1;
                s2_ff[g]   <= 1'b1;
                s3_ff[g]   <= 1'b1;
                filt_ff[g] <= 1'b1;
                prev_ff[g] <= 1'b1;
            end else if (clk_en) begin
                s1_ff[g]   <= pin_raw[g];
                s2_ff[g]   <= s1_ff[g];
                s3_ff[g]   <= s2_ff[g];
                prev_ff[g] <= filt_ff[g];
                if (s2_ff[g] == s3_ff[g]) begin
                    filt_ff[g] <= s3_ff[g];
                end
            end
        end
    end
    assign scl_f = filt_ff[0];
    assign sda_f = filt_ff[1];
    assign osc_f = filt_ff[2];

    // edges and bus conditions on the filtered lines
    assign scl_rise = scl_f && !prev_ff[0];
    assign scl_fall = !scl_f && prev_ff[0];
    assign start_c  = scl_f && prev_ff[0] && !sda_f && prev_ff[1];
    assign stop_c   = scl_f && prev_ff[0] && sda_f && !prev_ff[1];
    assign ireset   = osc_f && !ovr_ff;

    // override entry watches the pin pattern while held in reset
    assign pat_now  = RSW_OVR_SEQ[{step_ff, 1'b0} +: 2];
    assign pat_next = RSW_OVR_SEQ[{step_ff + 2'h1, 1'b0} +: 2];
    always_ff @(posedge core_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            ovr_ff  <= 1'b0;
            step_ff <= 2'h0;
            hold_ff <= '0;
        end else if (clk_en) begin
            if (!override_permit_bit) begin
                ovr_ff  <= 1'b0;
                step_ff <= 2'h0;
                hold_ff <= '0;
            end else if (ovr_ff || !osc_f) begin
                step_ff <= 2'h0;
                hold_ff <= '0;
            end else if (step_ff == 2'h3 && hold_ff >= OVR_HOLD) begin
                ovr_ff  <= 1'b1;
                step_ff <= 2'h0;
                hold_ff <= '0;
            end else if ({scl_f, sda_f} == pat_now) begin
                if (hold_ff < OVR_HOLD) begin
                    hold_ff <= hold_ff + 32'h1;
                end
            end else if (hold_ff >= OVR_HOLD &&
                         {scl_f, sda_f} == pat_next) begin
                step_ff <= step_ff + 2'h1;
                hold_ff <= '0;
            end else begin
                step_ff <= 2'h0; // pattern broken, start over
                hold_ff <= '0;
            end
        end
    end

    // a full byte sits in the shifter after the eighth rising clock
    assign byte_in = (bit_ff == 4'h8);
    // a write byte is only taken when the fifo has room
    assign push    = (st_ff == ST_WDATA) && scl_fall && byte_in &&
                     !start_c && !stop_c && !wdog_fire && !ireset &&
                     wr_ready_i;

    // byte sequencer
    always_ff @(posedge core_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            st_ff    <= ST_IDLE;
            after_ff <= ST_IDLE;
            bit_ff   <= 4'h0;
            shr_ff   <= 8'h00;
        end else if (clk_en) begin
            if (ireset || wdog_fire) begin
                st_ff  <= ST_IDLE;
                bit_ff <= 4'h0;
            end else if (start_c) begin
                st_ff  <= ST_ADDR;
                bit_ff <= 4'h0;
            end else if (stop_c) begin
                st_ff  <= ST_IDLE;
                bit_ff <= 4'h0;
            end else begin
                unique case (st_ff)
                    ST_IDLE, ST_WAITP: begin
                    end
                    ST_ADDR, ST_REG, ST_WDATA: begin
                        if (scl_rise && !byte_in) begin
                            shr_ff <= {shr_ff[6:0], sda_f};
                            bit_ff <= bit_ff + 4'h1;
                        end else if (scl_fall && byte_in) begin
                            bit_ff <= 4'h0;
                            if (st_ff == ST_ADDR) begin
                                if (shr_ff == RSW_ADDR_WR) begin
                                    st_ff    <= ST_ACK;
                                    after_ff <= ST_REG;
                                end else if (shr_ff == RSW_ADDR_RD) begin
                                    st_ff    <= ST_ACK;
                                    after_ff <= ST_RDATA;
                                end else begin
                                    st_ff <= ST_WAITP; // not ours
                                end
                            end else if (st_ff == ST_REG || wr_ready_i) begin
                                st_ff    <= ST_ACK;
                                after_ff <= ST_WDATA;
                            end else begin
                                st_ff <= ST_WAITP; // fifo full: no ack
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            st_ff <= after_ff;
                            if (after_ff == ST_RDATA) begin
                                shr_ff <= rd_data;
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (scl_fall) begin
                            if (bit_ff == 4'h7) begin
                                st_ff  <= ST_MACK;
                                bit_ff <= 4'h0;
                            end else begin
                                shr_ff <= {shr_ff[6:0], 1'b1};
                                bit_ff <= bit_ff + 4'h1;
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise && sda_f) begin
                            st_ff <= ST_WAITP;
                        end else if (scl_fall) begin
                            st_ff  <= ST_RDATA;
                            shr_ff <= rd_data;
                        end
                    end
                endcase
            end
        end
    end

    // register pointer
    always_ff @(posedge core_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            ptr_ff <= RSW_PTR_RST;
        end else if (clk_en) begin
            if (ireset) begin
                ptr_ff <= RSW_PTR_RST;
            end else if (st_ff == ST_REG && scl_fall && byte_in &&
                         !start_c && !stop_c && !wdog_fire) begin
                ptr_ff <= shr_ff[RSW_IDX_LSB +: RSW_IDX_W];
            end else if (push) begin
                ptr_ff <= ptr_ff + 4'h1;
            end else if (st_ff == ST_RDATA && scl_fall && bit_ff == 4'h7 &&
                         !start_c && !stop_c && !wdog_fire) begin
                ptr_ff <= ptr_ff + 4'h1;
            end
        end
    end

    // sda drive is open drain; registered a cycle behind the sequencer,
    // far inside the data hold time of the bus
    always_ff @(posedge core_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            oe_ff <= 1'b0;
        end else if (clk_en) begin
            oe_ff <= (st_ff == ST_ACK) ||
                     (st_ff == ST_RDATA && !shr_ff[7]);
        end
    end

    // access window and watchdog
    always_ff @(posedge core_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            active_ff <= 1'b0;
            wdog_ff   <= '0;
            lost_ff   <= 1'b0;
        end else if (clk_en) begin
            lost_ff <= wdog_fire;
            if (ireset || stop_c || wdog_fire) begin
                active_ff <= 1'b0;
                wdog_ff   <= '0;
            end else if (active_ff) begin
                wdog_ff <= wdog_ff + 32'h1;
            end else if (st_ff == ST_ADDR && scl_fall && byte_in &&
                         !start_c && (shr_ff == RSW_ADDR_WR ||
                                      shr_ff == RSW_ADDR_RD)) begin
                active_ff <= 1'b1;
                wdog_ff   <= '0;
            end
        end
    end
    // fires exactly at the lower bound, so always inside the window
    assign wdog_fire = active_ff && (wdog_ff == WDOG_CYCLES - 1);

    // write path buffering toward the register file
    assign fifo_in.addr = ptr_ff;
    assign fifo_in.data = shr_ff;
    rsw_fifo #(
        .W     (RSW_WR_W),
        .DEPTH (RSW_FIFO_DEPTH)
    ) u_fifo (
        .clk       (core_clk),
        .rst_n     (rst_i_n),
        .clk_en    (clk_en),
        .in_valid  (push),
        .in_ready  (wr_ready_i),
        .in_data   (fifo_in),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  (wr_word)
    );

    // outputs
    assign sda_o           = 1'b0;
    assign sda_oe          = oe_ff;
    assign override_active = ovr_ff;
    assign time_freeze     = active_ff;
    assign sec_lost        = lost_ff;
    assign rd_addr         = ptr_ff;
endmodule

// ### inc/rsw_pkg.sv
// shared constants and types for the rtc serial slave with watchdog
package rsw_pkg;
    // clock rate and derived cycle counts
    localparam int unsigned RSW_CLK_MHZ      = 250;
    localparam int unsigned RSW_WDOG_TIME_MS = 1000;
    localparam int unsigned RSW_WDOG_CYC     =
        RSW_WDOG_TIME_MS * 1000 * RSW_CLK_MHZ;
    localparam int unsigned RSW_OVR_HOLD_NS  = 1000;
    localparam int unsigned RSW_OVR_HOLD_CYC =
        (RSW_OVR_HOLD_NS * RSW_CLK_MHZ + 999) / 1000;

    // slave address bytes
    localparam logic [7:0] RSW_ADDR_RD = 8'ha3;
    localparam logic [7:0] RSW_ADDR_WR = 8'ha2;

    // register index field of the register byte
    localparam int unsigned RSW_IDX_LSB = 0;
    localparam int unsigned RSW_IDX_W   = 4;
    localparam logic [3:0]  RSW_PTR_RST = 4'h0;

    // override pin pattern, {scl,sda} per step, step 0 in low bits
    localparam logic [7:0]  RSW_OVR_SEQ = 8'hd2;

    // write fifo shape
    localparam int unsigned RSW_FIFO_DEPTH = 8;

    // one write to the register file
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
    } rsw_wr_s;
    localparam int unsigned RSW_WR_W = $bits(rsw_wr_s);

    // slave sequencer states
    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_ADDR  = 8'h02,
        ST_REG   = 8'h04,
        ST_WDATA = 8'h08,
        ST_ACK   = 8'h10,
        ST_RDATA = 8'h20,
        ST_MACK  = 8'h40,
        ST_WAITP = 8'h80
    } rsw_state_e;
endpackage

// ### rtl/rsw_fifo.sv
// parameterised valid/ready fifo for register writes
`timescale 1ns/1ns
module rsw_fifo #(
    parameter int unsigned W     = 12,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [W-1:0] mem_ff [DEPTH];
    logic [AW:0]  wp_ff;
    logic [AW:0]  rp_ff;
    logic         push;
    logic         pop;

    // extra pointer bit tells full from empty
    assign in_ready  = (wp_ff[AW] == rp_ff[AW]) ||
                       (wp_ff[AW-1:0] != rp_ff[AW-1:0]);
    assign out_valid = (wp_ff != rp_ff);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_ff[rp_ff[AW-1:0]];

    // storage, no reset needed on the data words
    always_ff @(posedge clk) begin
        if (clk_en && push) begin
            mem_ff[wp_ff[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_ff <= '0;
            rp_ff <= '0;
        end else if (clk_en) begin
            if (push) begin
                wp_ff <= wp_ff + 1'b1;
            end
            if (pop) begin
                rp_ff <= rp_ff + 1'b1;
            end
        end
    end
endmodule

// ### verification/rsw_slave_asserts.sv
// concurrent checks on the ports of the rtc serial slave
`timescale 1ns/1ns
module rsw_slave_asserts
    import rsw_pkg::*;
#(
    parameter int unsigned WDOG_CYCLES = RSW_WDOG_CYC,
    parameter int unsigned OVR_HOLD    = RSW_OVR_HOLD_CYC
) (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_oe,
    input wire logic       osc_stopped,
    input wire logic       override_permit_bit,
    input wire logic       override_active,
    input wire logic       time_freeze,
    input wire logic       sec_lost,
    input wire logic [3:0] rd_addr,
    input wire logic       wr_valid,
    input wire logic       wr_ready,
    input wire rsw_wr_s    wr_word
);
    logic [31:0] run_ff;
    logic        frz_q_ff;
    logic [3:0]  ires_ff;

    // length of the latest freeze run, kept after it ends
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_ff <= '0;
        end else if (time_freeze) begin
            run_ff <= frz_q_ff ? run_ff + 32'h1 : 32'h1;
        end
    end

    // previous freeze level, marks the start of a run
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frz_q_ff <= 1'b0;
        end else begin
            frz_q_ff <= time_freeze;
        end
    end

    // cycles in internal reset; saturates so pin filter lag is covered
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ires_ff <= 4'h0;
        end else if (osc_stopped && !override_active) begin
            ires_ff <= (ires_ff == 4'hf) ? ires_ff : ires_ff + 4'h1;
        end else begin
            ires_ff <= 4'h0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // last override step on the pins with entry still permitted
    sequence s_ovr_last;
        scl_i && sda_i && $past(override_permit_bit);
    endsequence
    sequence s_wdog_end;
        run_ff >= WDOG_CYCLES - 2 ##1 !time_freeze;
    endsequence

    property p_ovr_entry;
        $rose(override_active) |-> s_ovr_last;
    endproperty
    property p_ovr_clear;
        !override_permit_bit |=> !override_active;
    endproperty
    property p_ires_quiet;
        ires_ff == 4'hf |-> !sda_oe && !time_freeze && rd_addr == RSW_PTR_RST;
    endproperty
    property p_oe_scl_low;
        $changed(sda_oe) |-> !scl_i;
    endproperty
    property p_oe_in_access;
        sda_oe |-> time_freeze || $past(time_freeze);
    endproperty
    property p_oe_bounded;
        $rose(sda_oe) |-> ##[1:200] !sda_oe;
    endproperty
    property p_sec_pulse;
        sec_lost |=> !sec_lost;
    endproperty
    property p_sec_cause;
        sec_lost |-> s_wdog_end;
    endproperty
    property p_run_max;
        run_ff <= WDOG_CYCLES + 2;
    endproperty
    property p_fifo_hold;
        wr_valid && !wr_ready |=> wr_valid && $stable(wr_word);
    endproperty

    a_ovr_entry: assert property (p_ovr_entry)
        else $error("override entered without pattern or permit");
    a_ovr_clear: assert property (p_ovr_clear)
        else $error("override kept with permit low");
    a_ires_quiet: assert property (p_ires_quiet)
        else $error("activity during internal reset");
    a_oe_scl_low: assert property (p_oe_scl_low)
        else $error("data drive changed with clock high");
    a_oe_in_access: assert property (p_oe_in_access)
        else $error("data driven outside an access");
    a_oe_bounded: assert property (p_oe_bounded)
        else $error("data line held low too long");
    a_sec_pulse: assert property (p_sec_pulse)
        else $error("lost second pulse too long");
    a_sec_cause: assert property (p_sec_cause)
        else $error("lost second without expiry");
    a_run_max: assert property (p_run_max)
        else $error("freeze outlived the watchdog");
    a_fifo_hold: assert property (p_fifo_hold)
        else $error("write word changed while stalled");
endmodule

bind rsw_slave rsw_slave_asserts #(
    .WDOG_CYCLES(WDOG_CYCLES),
    .OVR_HOLD   (OVR_HOLD)
) u_chk (
    .core_clk           (core_clk),
    .rst_n              (rst_n),
    .scl_i              (scl_i),
    .sda_i              (sda_i),
    .sda_oe             (sda_oe),
    .osc_stopped        (osc_stopped),
    .override_permit_bit(override_permit_bit),
    .override_active    (override_active),
    .time_freeze        (time_freeze),
    .sec_lost           (sec_lost),
    .rd_addr            (rd_addr),
    .wr_valid           (wr_valid),
    .wr_ready           (wr_ready),
    .wr_word            (wr_word)
);

// ### verification/rsw_master.sv
// behavioural two-wire bus master for the rtc serial slave
`timescale 1ns/1ns
module rsw_master (
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    // both lines idle high; the clock only runs inside frames
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // one 80 ns bit: data set while clock low, sampled before fall
    task automatic bit_x(input logic b, output logic r);
        #20 sda_pull = !b;
        #20 scl = 1'b1;
        #40 r = sda;
        scl = 1'b0;
    endtask
    task automatic start();
        #20 sda_pull = 1'b0;
        #20 scl = 1'b1;
        #40 sda_pull = 1'b1;
        #40 scl = 1'b0;
    endtask
    task automatic stop();
        #20 sda_pull = 1'b1;
        #20 scl = 1'b1;
        #40 sda_pull = 1'b0;
        #40;
    endtask
    // raw pin step, held well beyond the minimum hold
    task automatic pins(input logic [1:0] v);
        scl = v[1];
        sda_pull = !v[0];
        #60;
    endtask
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        ack = !r;
    endtask
    task automatic get(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(!more, r);
    endtask
endmodule

// ### verification/rsw_slave_tb_top.sv
// self-checking bench for the rtc serial slave
`timescale 1ns/1ns
module rsw_slave_tb_top;
    import rsw_pkg::*;
    localparam int unsigned WD = 3000;
    logic       core_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       osc = 1'b1;
    logic       permit = 1'b1;
    logic       wr_ready = 1'b0;
    logic       hold = 1'b0;
    logic       sda_oe, sda_pull, scl, sda, ovr, frz, sec, wr_valid, ack;
    logic       sda_o;
    logic [3:0] rd_addr;
    logic [7:0] d;
    logic [7:0] regs [16];
    logic [7:0] exp_regs [16];
    rsw_wr_s    wr_word;
    rsw_wr_s    expq [$];
    int         bad_count = 0;
    int         num_checks = 0;
    int         nsec = 0;

    always #2 core_clk = ~core_clk;
    assign sda = !(sda_pull || (sda_oe && !sda_o)); // pull-up when released
    rsw_master m (.scl(scl), .sda_pull(sda_pull), .sda(sda));
    rsw_slave #(.WDOG_CYCLES(WD), .OVR_HOLD(5)) dut (
        .core_clk           (core_clk),
        .rst_n              (rst_n),
        .clk_en             (1'b1),
        .scl_i              (scl),
        .sda_i              (sda),
        .sda_o              (sda_o),
        .sda_oe             (sda_oe),
        .osc_stopped        (osc),
        .override_permit_bit(permit),
        .override_active    (ovr),
        .time_freeze        (frz),
        .sec_lost           (sec),
        .rd_addr            (rd_addr),
        .rd_data            (regs[rd_addr]),
        .wr_valid           (wr_valid),
        .wr_ready           (wr_ready),
        .wr_word            (wr_word)
    );
    task automatic chk(input logic [11:0] seen, input logic [11:0] want);
        num_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // register file sink: pops writes, stalls at random
    always @(posedge core_clk) begin
        if (rst_n && wr_valid === 1'b1 && wr_ready) begin
            chk(wr_word, expq.size() ? expq.pop_front() : 'x);
            regs[wr_word.addr] <= wr_word.data;
        end
        if (sec === 1'b1) nsec++;
        #1 wr_ready <= hold ? 1'b0 : 1'($urandom);
    end
    // wait n edges, then step off the edge so pins never move on it
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic fin();
        m.stop();
        tick(10);
        chk(frz, 1'b0);
    endtask
    // write n bytes from idx; only the first nacc are taken
    task automatic wr(input logic [3:0] idx, input int n, input int nacc);
        m.start();
        m.put(RSW_ADDR_WR, ack);
        chk(ack, 1'b1);
        chk(frz, 1'b1);
        m.put({4'($urandom), idx}, ack);
        chk(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            // queued first: the sink may pop the word during the ack bit
            if (i < nacc) begin
                expq.push_back({idx, d});
                exp_regs[idx] = d;
            end
            m.put(d, ack);
            chk(ack, i < nacc);
            idx++;
        end
        fin();
    endtask
    task automatic rd(input logic [3:0] idx, input int n);
        m.start();
        m.put(RSW_ADDR_WR, ack);
        m.put({4'hf, idx}, ack);
        m.start();
        m.put(RSW_ADDR_RD, ack);
        chk(ack, 1'b1);
        for (int i = 0; i < n; i++) begin
            m.get(i < n - 1, d);
            chk(d, exp_regs[idx]);
            idx++;
        end
        fin();
    endtask
    task automatic ovr_try(input logic want);
        for (int k = 0; k < 4; k++) m.pins(RSW_OVR_SEQ[2*k+:2]);
        chk(ovr, want);
    endtask
    initial begin
        #300000;
        bad_count++;
        print_verdict();
    end
    initial begin
        void'($urandom(62789));
        for (int i = 0; i < 16; i++) begin
            regs[i] = 8'($urandom);
            exp_regs[i] = regs[i];
        end
        repeat (3) @(posedge core_clk);
        #1 rst_n = 1'b1;
        tick(20);
        // oscillator stopped: bus must be ignored
        m.start();
        m.put(RSW_ADDR_WR, ack);
        chk(ack, 1'b0);
        m.stop();
        ovr_try(1'b1);
        wr(4'($urandom), 2, 2);
        permit = 1'b0;
        tick(3);
        chk(ovr, 1'b0);
        ovr_try(1'b0);
        permit = 1'b1;
        ovr_try(1'b1);
        osc = 1'b0;
        permit = 1'b0; // normal mode with permit low
        tick(10);
        chk(ovr, 1'b0);
        // foreign address left unanswered
        do d = 8'($urandom); while (d[7:1] == 7'h51);
        m.start();
        m.put(d, ack);
        chk(ack, 1'b0);
        m.stop();
        repeat (3) wr(4'($urandom), 1 + $urandom % 4, 8);
        wr(4'hf, 2, 2); // pointer wraps
        tick(40);
        rd(4'he, 4);
        rd(4'($urandom), 6);
        // full buffer refuses the ninth byte, then drains
        hold = 1'b1;
        wr(4'($urandom), 9, 8);
        hold = 1'b0;
        tick(60);
        chk(12'(expq.size()), 12'h0);
        // stalled access: watchdog clears it once
        nsec = 0;
        m.start();
        m.put(RSW_ADDR_WR, ack);
        tick(WD - 50);
        chk(frz, 1'b1);
        tick(70);
        chk(frz, 1'b0);
        chk(12'(nsec), 12'h1);
        m.stop();
        wr(4'($urandom), 2, 2);
        print_verdict();
    end
endmodule
